// ---- design/synth_divider_pkg.sv ----
// Purpose: Shared constants for the dual-modulus synthesizer divide chain.
// Assumes: One 50 MHz system clock; VCO signals arrive as asynchronous levels.
// Notes:   Every count, preset and width used by the chain lives here.
// Overview of operation
// - The prescaler divides by 100 or 101 as a 10/11 stage feeding a decade stage.
// - The 10/11 stage divides by 11 only while both modulus controls are low, else by 10.
// - The decade ripple output goes low for one pulse in ten, giving 9x10 plus 1x11.
// - Divide-by-101 lasts until swallow terminal count, then divide-by-100 to main terminal.
// - The swallow counter is a decade low digit and a binary high digit preset to 00..99.
// - A load pulse presets both swallow digits and clears the latch, selecting divide-by-101.
// - High digit 1010 with low digit zero sets the latch and selects divide-by-100.
// - The main counter is two binary stages; the low loads 0..9 and the high always loads 2.
// - Main terminal is low stage bit zero high together with high stage at maximum, count 241.
// - Each main count is worth 100 input counts, so the ratio is 24200 minus (3200 + setting).
// - Setting 999 gives a ratio of 20001 and setting 000 gives 21000.
// - In lock the terminal output is a 10 kHz pulse train for the phase detector.
// - The programmable loop output is also divided by 1000 through three decade counters.
// - The fixed loop feedback divides by 2 then by 16, turning 32 MHz into 1 MHz.
package synth_divider_pkg;

  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned DIGIT_W         = 4;
  localparam int unsigned MAIN_W          = 8;
  localparam int unsigned NUM_DECADES     = 3;

  localparam logic [3:0]  DECADE_LAST     = 4'h9;
  localparam logic [3:0]  DM_LAST_DIV10   = 4'h9;
  localparam logic [3:0]  DM_LAST_DIV11   = 4'hA;

  localparam logic [3:0]  SWALLOW_HI_TERM = 4'hA;
  localparam logic [3:0]  SWALLOW_LO_TERM = 4'h0;

  localparam logic [3:0]  MAIN_HI_PRESET  = 4'h2;
  localparam logic [3:0]  MAIN_HI_MAX     = 4'hF;
  localparam logic [3:0]  MAIN_LO_MAX_SEL = 4'h9;
  localparam int unsigned MAIN_LSB_BIT    = 0;

  localparam int unsigned FIXED_DIV2_W    = 1;
  localparam int unsigned FIXED_DIV16_W   = 4;
  localparam int unsigned FIXED_DIV_W     = FIXED_DIV2_W + FIXED_DIV16_W;
  localparam logic [4:0]  FIXED_DIV_LAST  = 5'h1F;

  localparam logic [3:0]  DIGIT_RESET     = 4'h0;

endpackage

// ---- design/decade_stage.sv ----
// Purpose: Presettable up-counting decade stage with ripple detect.
// Assumes: Count and load are one-cycle qualifiers on the system clock.
// Notes:   The ripple output is combinational; the caller qualifies it.
`timescale 1ns/1ps
`default_nettype none
module decade_stage
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  // Control
  input  wire logic       i_load,
  input  wire logic [3:0] i_preset,
  input  wire logic       i_count,
  // Status
  output logic      [3:0] o_value,
  output logic            o_at_last
);

  logic [3:0] value_q;
  logic [3:0] value_d;

  always_comb
  begin
    value_d = value_q;
    if (i_load)
    begin
      value_d = i_preset;
    end
    else if (i_count)
    begin
      value_d = (value_q >= synth_divider_pkg::DECADE_LAST) ? 4'h0 : value_q + 4'h1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      value_q <= synth_divider_pkg::DIGIT_RESET;
    end
    else
    begin
      value_q <= value_d;
    end
  end

  assign o_value   = value_q;
  assign o_at_last = (value_q == synth_divider_pkg::DECADE_LAST);

endmodule
`default_nettype wire

// ---- design/dual_modulus_synth_divider.sv ----
// Purpose: Divide chain of the programmable loop plus the fixed-loop feedback divider.
// Assumes: VCO levels are sampled by the 50 MHz clock, so each must stay well below 25 MHz.
// Notes:   Each synchronised rising VCO edge advances the chain by one input count.
`timescale 1ns/1ps
`default_nettype none
module dual_modulus_synth_divider
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  // VCO inputs from the two loops
  input  wire logic       i_prog_vco,
  input  wire logic       i_fixed_vco,
  // Three-digit BCD tuning setting
  input  wire logic [3:0] i_tune_hundreds,
  input  wire logic [3:0] i_tune_tens,
  input  wire logic [3:0] i_tune_units,
  // Chain outputs
  output logic            o_compare_pulse,
  output logic            o_prescaler_pulse,
  output logic            o_div1000_pulse,
  output logic            o_fixed_fb_pulse,
  output logic            o_swallow_modulus_ctrl
);

  // Clamps a digit to a legal BCD value so a bad setting cannot stall the chain.
  function automatic logic [3:0] clamp_bcd(input logic [3:0] digit);
    clamp_bcd = (digit > synth_divider_pkg::MAIN_LO_MAX_SEL) ? synth_divider_pkg::MAIN_LO_MAX_SEL
                                                              : digit;
  endfunction

  function automatic logic main_terminal(input logic [7:0] count);
    main_terminal = count[synth_divider_pkg::MAIN_LSB_BIT]
                    && (count[7:4] == synth_divider_pkg::MAIN_HI_MAX);
  endfunction

  // Two-flop synchronisers; only the second stage is read.
  logic [1:0]  prog_sync_q;
  logic [1:0]  fixed_sync_q;
  logic        prog_prev_q;
  logic        fixed_prev_q;
  logic [11:0] tune_meta_q;
  logic [11:0] tune_sync_q;

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      prog_sync_q  <= 2'h0;
      fixed_sync_q <= 2'h0;
      prog_prev_q  <= 1'h0;
      fixed_prev_q <= 1'h0;
      tune_meta_q  <= 12'h000;
      tune_sync_q  <= 12'h000;
    end
    else
    begin
      prog_sync_q  <= {prog_sync_q[0], i_prog_vco};
      fixed_sync_q <= {fixed_sync_q[0], i_fixed_vco};
      prog_prev_q  <= prog_sync_q[1];
      fixed_prev_q <= fixed_sync_q[1];
      tune_meta_q  <= {i_tune_hundreds, i_tune_tens, i_tune_units};
      tune_sync_q  <= tune_meta_q;
    end
  end

  logic vco_edge;
  logic fixed_edge;
  assign vco_edge   = prog_sync_q[1] & ~prog_prev_q;
  assign fixed_edge = fixed_sync_q[1] & ~fixed_prev_q;

  // Prescaler: 10/11 stage feeding a decade stage.
  logic [3:0] dm_q;
  logic [3:0] dm_d;
  logic       dm_wrap;
  logic       ripple_modulus_ctrl;
  logic       swallow_modulus_ctrl;
  logic       presc_at_last;
  logic       presc_pulse;

  // Ripple output is low for the tenth decade state only.
  assign ripple_modulus_ctrl = ~presc_at_last;
  assign dm_wrap = vco_edge && (dm_q == ((!swallow_modulus_ctrl && !ripple_modulus_ctrl)
                   ? synth_divider_pkg::DM_LAST_DIV11
                   : synth_divider_pkg::DM_LAST_DIV10));

  always_comb
  begin
    dm_d = dm_q;
    if (dm_wrap)
    begin
      dm_d = 4'h0;
    end
    else if (vco_edge)
    begin
      dm_d = dm_q + 4'h1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      dm_q <= synth_divider_pkg::DIGIT_RESET;
    end
    else
    begin
      dm_q <= dm_d;
    end
  end

  decade_stage u_presc_decade
  (
    .i_clk     (i_clk),
    .i_reset   (i_reset),
    .i_load    (1'b0),
    .i_preset  (synth_divider_pkg::DIGIT_RESET),
    .i_count   (dm_wrap),
    .o_value   (),
    .o_at_last (presc_at_last)
  );

  // One prescaler output per 100 or 101 VCO edges.
  assign presc_pulse = dm_wrap && presc_at_last;

  // Swallow counter, main counter and terminal latch.
  logic       load_pulse;
  logic [7:0] main_q;
  logic [7:0] main_d;
  logic [7:0] main_inc;
  logic       latch_q;
  logic       latch_d;
  logic [3:0] swallow_hi_q;
  logic [3:0] swallow_hi_d;
  logic       swallow_lo_last;
  logic       swallow_count;
  logic       compare_d;

  assign swallow_modulus_ctrl = latch_q;
  assign main_inc   = main_q + 8'h01;
  // Terminal is caught on the pulse that would reach 241, which then reloads instead.
  assign load_pulse = presc_pulse && main_terminal(main_inc);
  assign swallow_count = presc_pulse && !latch_q && !load_pulse;

  always_comb
  begin
    main_d       = main_q;
    swallow_hi_d = swallow_hi_q;
    latch_d      = latch_q;
    compare_d    = 1'b0;
    if (load_pulse)
    begin
      main_d       = {synth_divider_pkg::MAIN_HI_PRESET,
                      clamp_bcd(tune_sync_q[11:8])};
      swallow_hi_d = clamp_bcd(tune_sync_q[7:4]);
      latch_d      = 1'b0;
      compare_d    = 1'b1;
    end
    else
    begin
      if (presc_pulse)
      begin
        main_d = main_inc;
      end
      if (swallow_count && swallow_lo_last)
      begin
        swallow_hi_d = swallow_hi_q + 4'h1;
      end
      // Set once the high digit reaches ten with the low digit wrapping to zero.
      if (swallow_count && swallow_lo_last
          && (swallow_hi_q + 4'h1) == synth_divider_pkg::SWALLOW_HI_TERM)
      begin
        latch_d = 1'b1;
      end
    end
  end

  decade_stage u_swallow_lo
  (
    .i_clk     (i_clk),
    .i_reset   (i_reset),
    .i_load    (load_pulse),
    .i_preset  (clamp_bcd(tune_sync_q[3:0])),
    .i_count   (swallow_count),
    .o_value   (),
    .o_at_last (swallow_lo_last)
  );

  // Fixed-loop feedback: divide by 2 then by 16.
  logic [4:0] fixed_div_q;
  logic [4:0] fixed_div_d;
  logic       fixed_fb_d;

  always_comb
  begin
    fixed_div_d = fixed_div_q;
    fixed_fb_d  = 1'b0;
    if (fixed_edge)
    begin
      fixed_div_d = fixed_div_q + 5'h01;
      fixed_fb_d  = (fixed_div_q == synth_divider_pkg::FIXED_DIV_LAST);
    end
  end

  // Divide-by-1000 of the programmable VCO as three cascaded decades.
  logic       dec_last  [synth_divider_pkg::NUM_DECADES];
  logic       dec_en    [synth_divider_pkg::NUM_DECADES + 1];
  assign dec_en[0] = vco_edge;

  genvar gi;
  generate
    for (gi = 0; gi < synth_divider_pkg::NUM_DECADES; gi++)
    begin : g_dec
      decade_stage u_dec
      (
        .i_clk     (i_clk),
        .i_reset   (i_reset),
        .i_load    (1'b0),
        .i_preset  (synth_divider_pkg::DIGIT_RESET),
        .i_count   (dec_en[gi]),
        .o_value   (),
        .o_at_last (dec_last[gi])
      );
      assign dec_en[gi + 1] = dec_en[gi] && dec_last[gi];
    end
  endgenerate

  // Register state and outputs.
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      main_q                 <= {synth_divider_pkg::MAIN_HI_PRESET,
                                 synth_divider_pkg::DIGIT_RESET};
      swallow_hi_q           <= synth_divider_pkg::DIGIT_RESET;
      latch_q                <= 1'b0;
      fixed_div_q            <= 5'h00;
      o_compare_pulse        <= 1'b0;
      o_prescaler_pulse      <= 1'b0;
      o_div1000_pulse        <= 1'b0;
      o_fixed_fb_pulse       <= 1'b0;
      o_swallow_modulus_ctrl <= 1'b0;
    end
    else
    begin
      main_q                 <= main_d;
      swallow_hi_q           <= swallow_hi_d;
      latch_q                <= latch_d;
      fixed_div_q            <= fixed_div_d;
      o_compare_pulse        <= compare_d;
      o_prescaler_pulse      <= presc_pulse;
      o_div1000_pulse        <= dec_en[synth_divider_pkg::NUM_DECADES];
      o_fixed_fb_pulse       <= fixed_fb_d;
      o_swallow_modulus_ctrl <= latch_d;
    end
  end

endmodule
`default_nettype wire

// ---- tb/vco_model.sv ----
// Purpose: Slow square-wave VCO standing in for the oscillator at the chain input.
// Assumes: Each level lasts HALF system clocks, at least 2 so the synchronisers keep it.
// Notes:   The level stands still while i_run is low; rising edges are counted.
`timescale 1ns/1ps
`default_nettype none
module vco_model
#(
  parameter int HALF = 3
)
(
  // Clock and control
  input  wire logic       i_clk,
  input  wire logic       i_run,
  // Oscillator side
  output var logic        o_vco,
  output var int unsigned o_edges
);
  int ph;
  initial
  begin
    o_vco = 1'b0;
    o_edges = 0;
    ph = 0;
  end
  // Changes land 1 ns after the edge so the chain never samples a moving level.
  always @(posedge i_clk)
  begin
    #1;
    if (i_run)
    begin
      if (ph == HALF - 1)
      begin
        ph = 0;
        o_vco = ~o_vco;
        if (o_vco)
          o_edges++;
      end
      else
        ph++;
    end
  end
endmodule
`default_nettype wire

// ---- tb/synth_divider_checker.sv ----
// Purpose: Port-level assertions on the divide chain outputs.
// Assumes: VCO phases last at least 2 clocks, so prescaler pulses are far apart.
// Notes:   Control-line timing allows up to two clocks of register lag, and up to three after a compare pulse.
`timescale 1ns/1ps
`default_nettype none
module synth_divider_checker
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  // Inputs
  input  wire logic       i_prog_vco,
  input  wire logic       i_fixed_vco,
  input  wire logic [3:0] i_tune_hundreds,
  input  wire logic [3:0] i_tune_tens,
  input  wire logic [3:0] i_tune_units,
  // Outputs
  input  wire logic       o_compare_pulse,
  input  wire logic       o_prescaler_pulse,
  input  wire logic       o_div1000_pulse,
  input  wire logic       o_fixed_fb_pulse,
  input  wire logic       o_swallow_modulus_ctrl
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  wire logic cmp = o_compare_pulse;
  wire logic pre = o_prescaler_pulse;
  wire logic smc = o_swallow_modulus_ctrl;
  cmp_one_cycle_a: assert property (cmp |=> !cmp)
    else $error("compare pulse longer than one clock");
  cmp_on_pre_a: assert property (cmp |-> pre)
    else $error("compare pulse without prescaler output");
  pre_spacing_a: assert property (pre |=> !pre [*8])
    else $error("prescaler pulses too close");
  div1k_one_a: assert property (o_div1000_pulse |=> !o_div1000_pulse)
    else $error("divide-by-1000 pulse longer than one clock");
  fixed_one_a: assert property (o_fixed_fb_pulse |=> !o_fixed_fb_pulse)
    else $error("fixed feedback pulse longer than one clock");
  ctrl_moves_a: assert property ($changed(smc) |-> pre || $past(pre) || $past(pre, 2))
    else $error("modulus control changed away from a prescaler pulse");
  load_clears_a: assert property (cmp |-> ##[1:3] !smc)
    else $error("load did not clear the swallow latch");
  term_after_a: assert property (cmp |-> $past(smc))
    else $error("main terminal before swallow terminal");
  reset_quiet_a: assert property ($past(i_reset) |-> !(cmp || pre || smc || o_div1000_pulse))
    else $error("output active right after reset");
endmodule
bind dual_modulus_synth_divider synth_divider_checker u_chk (.i_clk(i_clk), .i_reset(i_reset),
  .i_prog_vco(i_prog_vco), .i_fixed_vco(i_fixed_vco), .i_tune_hundreds(i_tune_hundreds),
  .i_tune_tens(i_tune_tens), .i_tune_units(i_tune_units), .o_compare_pulse(o_compare_pulse),
  .o_prescaler_pulse(o_prescaler_pulse), .o_div1000_pulse(o_div1000_pulse),
  .o_fixed_fb_pulse(o_fixed_fb_pulse), .o_swallow_modulus_ctrl(o_swallow_modulus_ctrl));
`default_nettype wire

// ---- tb/dual_modulus_synth_divider_bench.sv ----
// Purpose: Self-checking bench for the prescaler, swallow phase and fixed dividers.
// Assumes: Programmable VCO period of 4 clocks, two clocks per level.
// Notes:   Only the untuned first cycle runs to its compare pulse; a tuned one is only begun.
`timescale 1ns/1ps
`default_nettype none
module dual_modulus_synth_divider_bench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        run = 1'b0;
  logic        pv;
  logic        fv;
  logic        cmp;
  logic        pre;
  logic        d1k;
  logic        ffb;
  logic        smc;
  int unsigned pe;
  int unsigned fe;
  int unsigned base;
  int unsigned nk = 0;
  int unsigned pz = 0;
  int unsigned fz = 0;
  logic [3:0]  tune_h = 4'h9;
  logic [3:0]  tune_t = 4'h9;
  logic [3:0]  tune_u = 4'hF;
  int          err_total = 0;
  int          n_checks = 0;
  always #10 clk = ~clk;
  vco_model #(.HALF(2)) u_pv (.i_clk(clk), .i_run(run), .o_vco(pv), .o_edges(pe));
  vco_model #(.HALF(4)) u_fv (.i_clk(clk), .i_run(run), .o_vco(fv), .o_edges(fe));
  dual_modulus_synth_divider u_dut (.i_clk(clk), .i_reset(rst), .i_prog_vco(pv),
    .i_fixed_vco(fv), .i_tune_hundreds(tune_h), .i_tune_tens(tune_t), .i_tune_units(tune_u),
    .o_compare_pulse(cmp), .o_prescaler_pulse(pre), .o_div1000_pulse(d1k),
    .o_fixed_fb_pulse(ffb), .o_swallow_modulus_ctrl(smc));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Waits for the next prescaler pulse and returns the VCO edges since the last one.
  task automatic next_pre(output int unsigned gap);
    int k;
    @(posedge clk);
    #1;
    for (k = 0; k < 1000 && pre !== 1'b1; k++)
    begin
      @(posedge clk);
      #1;
    end
    gap = pe - base;
    base = pe;
  endtask
  // Fresh start: the first cycle runs with swallow 00, so 100 cycles of 101 come first.
  task automatic test_div101();
    int unsigned g;
    int i;
    base = pe;
    for (i = 0; i < 4; i++)
    begin
      next_pre(g);
      check(g, 32'h65);
      check(smc, 1'b0);
    end
  endtask
  task automatic test_swallow_term();
    int unsigned g;
    int i;
    for (i = 4; i < 100; i++)
    begin
      next_pre(g);
      check(g, 32'h65);
    end
    check(smc, 1'b1);
    next_pre(g);
    check(g, 32'h64);
    check(smc, 1'b1);
  endtask
  // Untuned first cycle: 209 prescaler outputs, the last one the compare pulse at 21000 edges.
  task automatic test_chain_end();
    int unsigned g;
    int i;
    for (i = 101; i < 209; i++)
    begin
      next_pre(g);
      check(g, 32'h64);
      check(cmp, i == 208);
    end
    check(pe, 32'h5208);
    check(smc, 1'b0);
  endtask
  // Tens 9 and an out-of-range units digit clamped to 9 leave a single swallowed output.
  task automatic test_tuned();
    int unsigned g;
    next_pre(g);
    check(g, 32'h65);
    check(smc, 1'b1);
    next_pre(g);
    check(g, 32'h64);
  endtask
  // Called with the VCO models stopped, so their levels stand still across the reset.
  task automatic test_reset_mid();
    int unsigned g;
    rst = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check({cmp, pre, d1k, ffb, smc}, 5'h00);
    // A pin left high across reset reads as a fresh edge, so the counts start one lower.
    pz = pe - pv;
    fz = fe - fv;
    base = pz;
    rst = 1'b0;
    run = 1'b1;
    next_pre(g);
    check(g, 32'h65);
    check(smc, 1'b0);
  endtask
  // Pulses of the fixed dividers must land exactly on multiples of their ratios.
  always @(posedge clk)
  begin
    #1;
    if (ffb === 1'b1)
      check((fe - fz) % 32, 32'h0);
    if (d1k === 1'b1)
    begin
      nk++;
      check((pe - pz) % 1000, 32'h0);
    end
  end
  initial
  begin
    #(20 * 95000);
    err_total++;
    finish_test();
  end
  initial
  begin
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    run = 1'b1;
    test_div101();
    test_swallow_term();
    test_chain_end();
    test_tuned();
    run = 1'b0;
    repeat (10) @(posedge clk);
    #1;
    check(nk, pe / 1000);
    test_reset_mid();
    finish_test();
  end
endmodule
`default_nettype wire
